// ===== hdl/cpl_consts.vh
// Purpose: Shared constants of the colour palette lookup block.
// Assumes: APB register word index is the register-select code.
// Notes: Definitions only; included by bare name.
`ifndef CPL_CONSTS_VH
`define CPL_CONSTS_VH

// Register-select codes, also the word index on the bus.
`define CPL_RS_PTR_PAL_WR 4'h0
`define CPL_RS_PAL_DATA   4'h1
`define CPL_RS_MASK       4'h2
`define CPL_RS_PTR_PAL_RD 4'h3
`define CPL_RS_PTR_OVL_WR 4'h4
`define CPL_RS_OVL_DATA   4'h5
`define CPL_RS_RESERVED   4'h6
`define CPL_RS_PTR_OVL_RD 4'h7
`define CPL_RS_CTRL       4'h8

// Control register fields and reset values.
`define CPL_CTRL_WIDE_BIT 0
`define CPL_CTRL_PED_BIT  1
`define CPL_CTRL_RESET    2'h3
`define CPL_MASK_RESET    8'hff
`define CPL_PTR_RESET     8'h00

// Component counter steps.
`define CPL_CNT_RED       2'h0
`define CPL_CNT_GREEN     2'h1
`define CPL_CNT_BLUE      2'h2

// Overlay slot that is never stored.
`define CPL_OVL_NONE      4'h0
`define CPL_ZERO8         8'h00
`define CPL_ZERO24        24'h00_0000

`endif

// ===== hdl/cpl_skid_buf.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock; source and sink on the same clock.
// Notes: All outputs are flip-flops, so no combinational path crosses it.
module cpl_skid_buf #(
   parameter WIDTH = 26
) (
   // Clock and reset.
   input  wire             clk,
   input  wire             rst_n,
   // Filling side.
   input  wire             in_valid,
   output reg              in_ready_r,
   input  wire [WIDTH-1:0] in_data,
   // Draining side.
   output reg              out_valid_r,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data_r
);

   reg             skid_valid_r;
   reg [WIDTH-1:0] skid_data_r;
   wire            push = in_valid & in_ready_r;
   wire            pop  = out_valid_r & out_ready;

   // The skid entry catches one word when the sink stalls, so none is lost.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid_r  <= 1'b0;
         out_data_r   <= {WIDTH{1'b0}};
         skid_valid_r <= 1'b0;
         skid_data_r  <= {WIDTH{1'b0}};
         in_ready_r   <= 1'b1;
      end else if (!out_valid_r || pop) begin
         if (skid_valid_r) begin
            out_data_r   <= skid_data_r;
            out_valid_r  <= 1'b1;
            skid_valid_r <= 1'b0;
            in_ready_r   <= 1'b1;
         end else begin
            out_valid_r <= push;
            if (push) begin
               out_data_r <= in_data;
            end
         end
      end else if (push) begin
         skid_data_r  <= in_data;
         skid_valid_r <= 1'b1;
         in_ready_r   <= 1'b0;  // Full: back-pressure reaches the source.
      end
   end

endmodule // cpl_skid_buf

// ===== hdl/cpl_palette.v
// What this block does
// - Select codes: pointer loads 0,3,4,7; palette data 1; mask 2; overlay 5; 6 reserved.
// - Hidden counter steps red, green, blue; cleared by pointer write, not by read.
// - Blue write commits entry; every blue access increments pointer, palette wraps FF to 00.
// - Host updates reach pixel-side colour storage within one clock, any time.
// - Overlay access uses low four pointer bits; 1..15 select colours, 0 reserved.
// - Wide mode moves full 8-bit components, bit 0 least significant.
// - Narrow mode uses bits 0..5 on writes; bits 6,7 read as zero.
// - Overlay select zero uses masked index into palette; nonzero picks overlay colour.
// - Pixel index is ANDed with the host-writable mask before lookup.
// - Sync and blank are registered on the rising clock edge with the colour.
// - Blank forces blank level, sync also gives sync level; else colour with sync flag.
// - Pedestal select high gives 7.5 IRE setup, low gives 0 IRE.
//
// Purpose: Pixel lookup and host access of a 256-entry colour palette.
// Assumes: Pixel inputs come from logic on clk; host reaches registers over APB.
// Notes: Palette storage has no reset; write it before showing it.
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "cpl_consts.vh"

module cpl_palette #(
   parameter ENTRIES = 256,
   parameter OVL_N   = 16
) (
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_r,
   output reg         pready_r,
   output reg         pslverr_r,
   // Frame buffer side.
   input  wire        pix_valid,
   output wire        pix_ready,
   input  wire [7:0]  pixel_index,
   input  wire [3:0]  overlay_select,
   input  wire        sync_in_n,
   input  wire        blank_in_n,
   // Converter side.
   output wire        vid_valid,
   input  wire        vid_ready,
   output wire [7:0]  vid_red,
   output wire [7:0]  vid_green,
   output wire [7:0]  vid_blue,
   output wire        vid_sync_n,
   output wire        vid_blank_n,
   output reg         pedestal_en_r
);

   // Host-side state.
   reg  [7:0]  palette_pointer_r;
   reg  [1:0]  component_counter_r;
   reg  [7:0]  mask_r;
   reg         wide_r;
   reg  [7:0]  red_hold_r;
   reg  [7:0]  green_hold_r;
   reg  [23:0] pal_mem [0:ENTRIES-1];
   reg  [23:0] ovl_mem [1:OVL_N-1];
   integer     i;

   // Bus decode.
   wire [3:0]  idx      = paddr[5:2];
   wire        in_range = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
   wire        mapped   = in_range && (idx <= `CPL_RS_CTRL) && (idx != `CPL_RS_RESERVED);
   wire        setup    = psel & ~penable;
   wire        done     = psel & penable & pready_r;
   wire        wr_done  = done & pwrite & mapped;
   wire        rd_done  = done & ~pwrite & mapped;

   // Converts a bus byte into a stored 8-bit component.
   function [7:0] comp_in;
      input [7:0] d;
      input       wide;
      begin
         comp_in = wide ? d : {d[5:0], 2'b00};
      end
   endfunction

   // Converts a stored component back into a bus byte.
   function [7:0] comp_out;
      input [7:0] c;
      input       wide;
      begin
         comp_out = wide ? c : {2'b00, c[7:2]};
      end
   endfunction

   // Picks one component of an entry by counter value.
   function [7:0] comp_pick;
      input [23:0] e;
      input [1:0]  n;
      begin
         case (n)
            `CPL_CNT_RED:   comp_pick = e[23:16];
            `CPL_CNT_GREEN: comp_pick = e[15:8];
            default:        comp_pick = e[7:0];
         endcase
      end
   endfunction

   // Overlay slot from the pointer; upper bits are don't-care.
   wire [3:0]  ovl_slot  = palette_pointer_r[3:0];
   wire        slot_none = (ovl_slot == `CPL_OVL_NONE);
   wire [23:0] pal_ent   = pal_mem[palette_pointer_r];
   wire [23:0] ovl_ent   = slot_none ? `CPL_ZERO24 : ovl_mem[ovl_slot];
   wire        is_pal    = (idx == `CPL_RS_PAL_DATA);
   wire        is_ovl    = (idx == `CPL_RS_OVL_DATA);
   wire        data_acc  = (wr_done | rd_done) & (is_pal | is_ovl);
   wire        blue_step = data_acc && (component_counter_r == `CPL_CNT_BLUE);
   wire        ptr_wr    = wr_done && ((idx == `CPL_RS_PTR_PAL_WR) ||
                           (idx == `CPL_RS_PTR_PAL_RD) || (idx == `CPL_RS_PTR_OVL_WR) ||
                           (idx == `CPL_RS_PTR_OVL_RD));
   wire [23:0] new_ent   = {red_hold_r, green_hold_r, comp_in(pwdata[7:0], wide_r)};
   wire        commit    = wr_done && (component_counter_r == `CPL_CNT_BLUE);

   // Read data for the current address.
   reg  [7:0]  rd_byte;
   always @* begin
      rd_byte = `CPL_ZERO8;
      case (idx)
         `CPL_RS_PTR_PAL_WR, `CPL_RS_PTR_PAL_RD,
         `CPL_RS_PTR_OVL_WR, `CPL_RS_PTR_OVL_RD: begin
            rd_byte = palette_pointer_r;  // Reading the pointer disturbs nothing.
         end
         `CPL_RS_PAL_DATA: begin
            rd_byte = comp_out(comp_pick(pal_ent, component_counter_r), wide_r);
         end
         `CPL_RS_OVL_DATA: begin
            rd_byte = comp_out(comp_pick(ovl_ent, component_counter_r), wide_r);
         end
         `CPL_RS_MASK: begin
            rd_byte = mask_r;
         end
         `CPL_RS_CTRL: begin
            rd_byte = {6'h00, pedestal_en_r, wide_r};
         end
         default: begin
            rd_byte = `CPL_ZERO8;
         end
      endcase
   end

   // Answer is prepared in the setup cycle so every access takes one wait-free cycle.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & ~mapped;  // Unmapped and reserved words answer with an error.
         prdata_r  <= (setup & ~pwrite & mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Pointer, counter and component holds.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         palette_pointer_r   <= `CPL_PTR_RESET;
         component_counter_r <= `CPL_CNT_RED;
         red_hold_r          <= `CPL_ZERO8;
         green_hold_r        <= `CPL_ZERO8;
      end else if (ptr_wr) begin
         palette_pointer_r   <= pwdata[7:0];
         component_counter_r <= `CPL_CNT_RED;
      end else if (data_acc) begin
         if (pwrite && component_counter_r == `CPL_CNT_RED) begin
            red_hold_r <= comp_in(pwdata[7:0], wide_r);
         end
         if (pwrite && component_counter_r == `CPL_CNT_GREEN) begin
            green_hold_r <= comp_in(pwdata[7:0], wide_r);
         end
         if (blue_step) begin
            component_counter_r <= `CPL_CNT_RED;
            palette_pointer_r   <= palette_pointer_r + 8'h01;  // Wraps FF to 00.
         end else begin
            component_counter_r <= component_counter_r + 2'h1;
         end
      end
   end

   // Mask and control registers.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r        <= `CPL_MASK_RESET;
         wide_r        <= 1'b1;
         pedestal_en_r <= 1'b1;
      end else if (wr_done && idx == `CPL_RS_MASK) begin
         mask_r <= pwdata[7:0];  // May change at any time.
      end else if (wr_done && idx == `CPL_RS_CTRL) begin
         wide_r        <= pwdata[`CPL_CTRL_WIDE_BIT];
         pedestal_en_r <= pwdata[`CPL_CTRL_PED_BIT];
      end
   end

   // Palette entries are written whole at the blue step; the pixel side
   // reads the same storage, so the new colour shows on the next clock.
   always @(posedge clk) begin
      if (commit && is_pal) begin
         pal_mem[palette_pointer_r] <= new_ent;
      end
   end

   // Overlay colours; slot zero is never stored.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 1; i < OVL_N; i = i + 1) begin
            ovl_mem[i] <= `CPL_ZERO24;
         end
      end else if (commit && is_ovl && !slot_none) begin
         ovl_mem[ovl_slot] <= new_ent;
      end
   end

   // Pixel lookup: masked index into the palette, or an overlay colour.
   wire [7:0]  masked_index = pixel_index & mask_r;
   wire [23:0] pix_colour   = (overlay_select == `CPL_OVL_NONE) ?
                              pal_mem[masked_index] :
                              ovl_mem[overlay_select];
   // Blank forces the blank code; sync travels as a flag for the converters.
   wire [23:0] out_colour   = blank_in_n ? pix_colour : `CPL_ZERO24;

   // The buffer registers colour, sync and blank together at the rising edge,
   // so all three leave with the same latency and a stall loses no word.
   wire [25:0] buf_out;
   cpl_skid_buf #(
      .WIDTH(26)
   ) u_buf (
      .clk        (clk),
      .rst_n      (rst_n),
      .in_valid   (pix_valid),
      .in_ready_r (pix_ready),
      .in_data    ({sync_in_n, blank_in_n, out_colour}),
      .out_valid_r(vid_valid),
      .out_ready  (vid_ready),
      .out_data_r (buf_out)
   );

   // Converter channels; a low sync with low blank gives the sync level.
   assign vid_sync_n  = buf_out[25];
   assign vid_blank_n = buf_out[24];
   assign vid_red     = buf_out[23:16];
   assign vid_green   = buf_out[15:8];
   assign vid_blue    = buf_out[7:0];

endmodule // cpl_palette

// ===== testbench/cpl_palette_chk.sv
// Purpose: Port checker of the palette block.
// Assumes: One clock; reset active low.
// Notes: Follows the width bit written by the host to judge reads.
module cpl_palette_chk (
   // Clock and reset.
   input wire        clk,
   input wire        rst_n,
   // APB.
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata_r,
   input wire        pready_r,
   input wire        pslverr_r,
   // Pixel stream.
   input wire        pix_valid,
   input wire        pix_ready,
   input wire        sync_in_n,
   input wire        blank_in_n,
   input wire        vid_valid,
   input wire        vid_ready,
   input wire [7:0]  vid_red,
   input wire [7:0]  vid_green,
   input wire [7:0]  vid_blue,
   input wire        vid_sync_n,
   input wire        vid_blank_n,
   input wire        pedestal_en_r
);
   timeunit 1ns;
   timeprecision 1ns;
   reg wide_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Copy of the width bit, needed because it is not visible at the ports.
   always @(posedge clk or negedge rst_n)
      if (!rst_n) wide_r <= 1'b1;
      else if (psel && penable && pready_r && pwrite && paddr == 8'h20) wide_r <= pwdata[0];
   AST_ACK: assert property (psel && !penable |=> pready_r)
      else $error("no answer after setup");
   AST_PULSE: assert property (pready_r |=> !pready_r)
      else $error("ready stood two cycles");
   AST_RSVD: assert property (psel && !penable && paddr == 8'h18 |=> pslverr_r)
      else $error("reserved word not refused");
   AST_NARROW: assert property (pready_r && !pwrite && !wide_r &&
      (paddr == 8'h04 || paddr == 8'h14) |-> prdata_r[31:6] == 26'h0)
      else $error("narrow read has high bits");
   AST_PED: assert property (psel && penable && pready_r && pwrite && paddr == 8'h20
      |=> pedestal_en_r == $past(pwdata[1])) else $error("pedestal bit not taken");
   AST_LAT: assert property (pix_valid && pix_ready && !vid_valid |=> vid_valid &&
      vid_sync_n == $past(sync_in_n) && vid_blank_n == $past(blank_in_n))
      else $error("controls not one cycle behind");
   AST_BLANK: assert property (vid_valid && !vid_blank_n |->
      {vid_red, vid_green, vid_blue} == 24'h00_0000) else $error("colour while blanked");
   AST_HOLD: assert property (vid_valid && !vid_ready |=> vid_valid &&
      $stable({vid_red, vid_green, vid_blue, vid_sync_n, vid_blank_n}))
      else $error("word changed during stall");
   COV_FULL: cover property (pix_valid && !pix_ready);
   COV_BLANK: cover property (vid_valid && !vid_blank_n);
   COV_ERR: cover property (pslverr_r);
endmodule // cpl_palette_chk

// ===== testbench/cpl_sink_model.sv
// Purpose: Converter-side sink that can stall the colour stream.
// Assumes: Same clock as the block.
// Notes: Ready lags the stall request by one edge, like real sink logic.
module cpl_sink_model (
   // Clock and reset.
   input  wire  clk,
   input  wire  rst_n,
   // Bench control and handshake.
   input  wire  stall,
   output logic vid_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // Registered ready, so it only changes in the edge's own time step.
   always @(posedge clk or negedge rst_n)
      if (!rst_n) vid_ready <= 1'b0;
      else vid_ready <= !stall;
endmodule // cpl_sink_model

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench of the palette block.
// Assumes: APB answers in one access cycle; the sink stalls on request.
// Notes: Palette entries are written before they are shown.
`include "cpl_consts.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, psel, penable, pwrite, pix_valid, sync_in_n, blank_in_n, stall;
   logic [7:0]  paddr, pixel_index, vid_red, vid_green, vid_blue;
   logic [31:0] pwdata, prdata_r, rd;
   logic [3:0]  overlay_select;
   logic        pready_r, pslverr_r, pix_ready, vid_valid, vid_ready, vid_sync_n, vid_blank_n;
   logic        pedestal_en_r, err;
   logic [25:0] w, q[$];
   logic [23:0] e;
   int          err_count, samples_checked, cycles, i;
   // Rows: index, overlay select, sync, blank, expected colour.
   logic [37:0] rows [0:5] = '{{8'h05, 4'h0, 2'b11, 24'h11_2233},
      {8'hff, 4'h0, 2'b11, 24'ha1_b2c3}, {8'h00, 4'h0, 2'b11, 24'h44_5566},
      {8'h12, 4'h3, 2'b11, 24'h77_8899}, {8'h05, 4'h0, 2'b10, 24'h00_0000},
      {8'h05, 4'h0, 2'b01, 24'h11_2233}};
   cpl_palette DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
      .pslverr_r(pslverr_r), .pix_valid(pix_valid), .pix_ready(pix_ready),
      .pixel_index(pixel_index), .overlay_select(overlay_select), .sync_in_n(sync_in_n),
      .blank_in_n(blank_in_n), .vid_valid(vid_valid), .vid_ready(vid_ready),
      .vid_red(vid_red), .vid_green(vid_green), .vid_blue(vid_blue),
      .vid_sync_n(vid_sync_n), .vid_blank_n(vid_blank_n), .pedestal_en_r(pedestal_en_r));
   cpl_sink_model u_sink (.clk(clk), .rst_n(rst_n), .stall(stall), .vid_ready(vid_ready));
   // Clock of 50 ns period.
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   // Collects every word the sink accepts.
   always @(posedge clk)
      if (vid_valid === 1'b1 && vid_ready === 1'b1)
         q.push_back({vid_red, vid_green, vid_blue, vid_sync_n, vid_blank_n});
   // One APB transfer; holds the request until ready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready_r !== 1'b1 && n < 16);
      // A bus that never answers counts as a mismatch.
      if (pready_r !== 1'b1) err_count++;
      rd = prdata_r;
      err = pslverr_r;
      psel <= 0;
      penable <= 0;
   endtask
   // Red, green and blue writes of one entry.
   task automatic rgb(input logic [7:0] a, input logic [23:0] c);
      for (int k = 0; k < 3; k++) apb(1, a, {24'h00_0000, c[23-8*k -: 8]});
   endtask
   // Offers one pixel word until the block takes it.
   task automatic pix(input logic [37:0] r);
      int n;
      @(posedge clk);
      {pixel_index, overlay_select, sync_in_n, blank_in_n} <= r[37:24];
      pix_valid <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pix_ready !== 1'b1 && n < 16);
      // A stream that never takes the word counts as a mismatch.
      if (pix_ready !== 1'b1) err_count++;
      pix_valid <= 0;
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, pix_valid, stall, paddr, pwdata, pixel_index} = 0;
      {overlay_select, sync_in_n, blank_in_n, rst_n} = 7'h06;
      repeat (4) @(posedge clk);
      rst_n <= 1;
      `CHK(pix_ready, 1'b1)
      `CHK(pedestal_en_r, 1'b1)
      apb(0, 8'h08, 0);
      `CHK(rd[7:0], `CPL_MASK_RESET)
      $display("reset test done");
      apb(1, 8'h00, 32'h0000_0005);
      rgb(8'h04, 24'h11_2233);
      apb(1, 8'h00, 32'h0000_00ff);
      rgb(8'h04, 24'ha1_b2c3);
      rgb(8'h04, 24'h44_5566); // Lands in entry 00 after the wrap.
      apb(1, 8'h10, 32'h0000_00f3);
      rgb(8'h14, 24'h77_8899);
      for (i = 0; i < 6; i++) pix(rows[i]);
      repeat (3) @(posedge clk);
      `CHK(q.size(), 6)
      for (i = 0; i < 6; i++) begin
         w = q.pop_front();
         `CHK(w, {rows[i][23:0], rows[i][25:24]})
      end
      apb(1, 8'h08, 32'h0000_000f);
      pix({8'hf5, 4'h0, 2'b11, 24'h00_0000});
      repeat (3) @(posedge clk);
      w = q.pop_front();
      `CHK(w, {24'h11_2233, 2'b11})
      $display("pixel table test done");
      apb(1, 8'h0c, 32'h0000_00ff);
      apb(0, 8'h04, 0);
      `CHK(rd, 32'h0000_00a1)
      apb(0, 8'h04, 0);
      apb(0, 8'h04, 0);
      apb(0, 8'h04, 0);
      `CHK(rd[7:0], 8'h44)
      apb(0, 8'h0c, 0);
      `CHK(rd[7:0], 8'h00)
      apb(0, 8'h04, 0);
      `CHK(rd[7:0], 8'h55)
      apb(1, 8'h20, 0);
      @(negedge clk);
      `CHK(pedestal_en_r, 1'b0)
      apb(1, 8'h00, 32'h0000_0010);
      rgb(8'h04, 24'h3f_ff01);
      apb(1, 8'h0c, 32'h0000_0010);
      e = 24'h3f_3f01;
      for (i = 0; i < 3; i++) begin
         apb(0, 8'h04, 0);
         `CHK(rd, {24'h00_0000, e[23-8*i -: 8]})
      end
      apb(1, 8'h20, 32'h0000_0003);
      apb(1, 8'h10, 32'h0000_0000);
      rgb(8'h14, 24'h12_3456);
      apb(0, 8'h1c, 0);
      `CHK(rd[7:0], 8'h01)
      apb(1, 8'h1c, 32'h0000_0000);
      for (i = 0; i < 3; i++) begin
         apb(0, 8'h14, 0);
         `CHK(rd, 32'h0000_0000)
      end
      apb(0, 8'h18, 0);
      `CHK(err, 1'b1)
      apb(0, 8'h24, 0);
      `CHK(err, 1'b1)
      $display("host access test done");
      // Full mask again, so both stalled words address written entries.
      apb(1, 8'h08, 32'h0000_00ff);
      stall <= 1;
      pix(rows[0]);
      pix(rows[1]);
      @(negedge clk);
      `CHK(pix_ready, 1'b0)
      @(posedge clk);
      stall <= 0;
      repeat (6) @(posedge clk);
      `CHK(q.size(), 2)
      w = q.pop_front();
      `CHK(w, {rows[0][23:0], rows[0][25:24]})
      w = q.pop_front();
      `CHK(w, {rows[1][23:0], rows[1][25:24]})
      $display("stall test done");
      end_of_test();
   end
endmodule // tb_top
bind cpl_palette cpl_palette_chk u_chk (.*);
